// ---- logic/ucr_pkg.sv ----
package ucr_pkg;
  // Register index addresses
  localparam logic [7:0] UCR_A_BASE_ADDR = 8'h0E;
  localparam logic [7:0] UCR_A_IRQ_ADDR = 8'h10;
  localparam logic [7:0] UCR_B_EN_ADDR = 8'h11;
  localparam logic [7:0] UCR_B_MODE_ADDR = 8'h12;
  localparam logic [7:0] UCR_B_BASE_ADDR = 8'h13;
  // Values after reset
  localparam logic [7:0] UCR_A_BASE_RST = 8'h00;
  localparam logic [7:0] UCR_A_IRQ_RST = 8'hF0;
  localparam logic [7:0] UCR_B_EN_RST = 8'hF8;
  localparam logic [7:0] UCR_B_MODE_RST = 8'hC4;
  localparam logic [7:0] UCR_B_BASE_RST = 8'h00;
  // Masks of writable bits; the rest read as ones
  localparam logic [7:0] UCR_IRQ_WMASK = 8'h0F;
  localparam logic [7:0] UCR_EN_WMASK = 8'h07;
  localparam logic [7:0] UCR_MODE_WMASK = 8'h3F;
  // Field positions
  localparam int UCR_EN_BIT = 0;
  localparam int UCR_APM_BIT = 1;
  localparam int UCR_LEAK_BIT = 2;
  localparam int UCR_TEST_BIT = 0;
  localparam int UCR_IR_BIT = 1;
  localparam int UCR_DUPLEX_BIT = 2;
  localparam int UCR_IRMODE_LSB = 3;
  // I/O base formula
  localparam logic [11:0] UCR_IO_OFFSET = 12'h100;
  localparam logic [2:0] UCR_IRMODE_ASK = 3'h2;
endpackage

// ---- logic/ucr_uart_config_registers.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
// Notes on behaviour
// RL1: I/O base of each UART is eight times base select plus 100h.
// RL2: Interrupt code maps to lines 3-7, 9-11, 14, 15; others none.
// RL3: Reserved bits of every UART configuration register read as ones.
// RL4: Second UART enable clear removes decode and powers it down.
// RL5: Enable register bit 1 turns automatic power management on.
// RL6: Leakage bit floats outputs and blocks inputs during power-down.
// RL7: Mode register bit 0 enables the second UART test mode.
// RL8: Infrared bit routes second UART data to infrared pins.
// RL9: Duplex bit gives full duplex at zero, half at one, with infrared.
// RL10: Infrared mode field picks pulse format; codes 3 to 7 reserved.
// RL11: Writes to reserved bits are ignored so they still read ones.
module ucr_uart_config_registers
  import ucr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // First UART settings
  output logic [11:0] uart_a_io_base,
  output logic [15:0] uart_a_irq_lines,
  // Second UART settings
  output logic [11:0] uart_b_io_base,
  output logic uart_b_decode_en,
  output logic uart_b_power_down,
  output logic uart_b_auto_pm_en,
  output logic uart_b_pins_isolate,
  output logic uart_b_test_mode,
  output logic uart_b_ir_select,
  output logic uart_b_half_duplex,
  output logic [2:0] uart_b_ir_mode,
  output logic uart_b_ir_mode_valid,
  // Second UART pin routing
  input wire logic second_serial_in_pin,
  input wire logic infrared_receive_pin,
  input wire logic uart_b_tx_data,
  output logic uart_b_rx_data,
  output logic second_serial_out_pin,
  output logic second_serial_out_oe,
  output logic infrared_transmit_pin,
  output logic infrared_transmit_oe
);

  // Decoded line set for one interrupt code; reserved codes route nothing
  function automatic logic [15:0] irq_decode(input logic [3:0] code);
    logic [15:0] lines;
    lines = 16'h0000;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF: begin
        lines[code] = 1'b1;
      end
      default: begin
        lines = 16'h0000;
      end
    endcase
    return lines;
  endfunction

  // Base select to 12-bit I/O address
  function automatic logic [11:0] io_base(input logic [7:0] sel);
    return {1'b0, sel, 3'h0} + UCR_IO_OFFSET;
  endfunction

  // Stored registers
  logic [7:0] a_base;
  logic [7:0] a_irq;
  logic [7:0] b_en;
  logic [7:0] b_mode;
  logic [7:0] b_base;

  // Write decode
  wire logic wr_a_base = reg_write && (reg_addr == UCR_A_BASE_ADDR);
  wire logic wr_a_irq = reg_write && (reg_addr == UCR_A_IRQ_ADDR);
  wire logic wr_b_en = reg_write && (reg_addr == UCR_B_EN_ADDR);
  wire logic wr_b_mode = reg_write && (reg_addr == UCR_B_MODE_ADDR);
  wire logic wr_b_base = reg_write && (reg_addr == UCR_B_BASE_ADDR);

  // Reserved bits forced high on write
  wire logic [7:0] next_a_irq = (reg_wdata & UCR_IRQ_WMASK) | ~UCR_IRQ_WMASK; // RL11
  wire logic [7:0] next_b_en = (reg_wdata & UCR_EN_WMASK) | ~UCR_EN_WMASK; // RL11
  wire logic [7:0] next_b_mode = (reg_wdata & UCR_MODE_WMASK) | ~UCR_MODE_WMASK; // RL11

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      a_base <= UCR_A_BASE_RST;
      a_irq <= UCR_A_IRQ_RST;
      b_en <= UCR_B_EN_RST;
      b_mode <= UCR_B_MODE_RST;
      b_base <= UCR_B_BASE_RST;
    end else begin
      if (wr_a_base) a_base <= reg_wdata;
      if (wr_a_irq) a_irq <= next_a_irq;
      if (wr_b_en) b_en <= next_b_en;
      if (wr_b_mode) b_mode <= next_b_mode;
      if (wr_b_base) b_base <= reg_wdata;
    end
  end

  // Read select; unmapped indexes read as zero
  logic [7:0] next_rdata;
  always_comb begin
    case (reg_addr)
      UCR_A_BASE_ADDR: next_rdata = a_base;
      UCR_A_IRQ_ADDR: next_rdata = a_irq | ~UCR_IRQ_WMASK; // RL3
      UCR_B_EN_ADDR: next_rdata = b_en | ~UCR_EN_WMASK; // RL3
      UCR_B_MODE_ADDR: next_rdata = b_mode | ~UCR_MODE_WMASK; // RL3
      UCR_B_BASE_ADDR: next_rdata = b_base;
      default: next_rdata = 8'h00;
    endcase
  end

  // Settings decoded from stored bits
  wire logic b_on = b_en[UCR_EN_BIT];
  wire logic b_ir = b_mode[UCR_IR_BIT];
  wire logic [2:0] b_irmode = b_mode[UCR_IRMODE_LSB +: 3];
  // Pins held off only while powered down with leakage control set
  wire logic b_isolate = !b_on && b_en[UCR_LEAK_BIT]; // RL6
  wire logic b_rx_src = b_ir ? infrared_receive_pin : second_serial_in_pin; // RL8

  // Next values of the registered outputs
  wire logic [7:0] next_reg_rdata = reg_read ? next_rdata : 8'h00;
  wire logic [11:0] next_a_io_base = io_base(a_base); // RL1
  wire logic [15:0] next_a_irq_lines = irq_decode(a_irq[3:0]); // RL2
  wire logic [11:0] next_b_io_base = io_base(b_base); // RL1
  wire logic next_b_half_duplex = b_ir && b_mode[UCR_DUPLEX_BIT]; // RL9
  wire logic next_b_ir_mode_valid = (b_irmode <= UCR_IRMODE_ASK); // RL10
  // Blocked input idles high so the receiver sees no start bit
  wire logic next_b_rx_data = b_isolate ? 1'h1 : b_rx_src; // RL6
  wire logic next_serial_out_oe = !b_ir && !b_isolate; // RL8
  wire logic next_ir_out_oe = b_ir && !b_isolate; // RL8

  // Read data stands for each cycle of read strobe, then returns to zero once the strobe drops
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // First UART settings; all settings lag a write by one cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      uart_a_io_base <= UCR_IO_OFFSET;
      uart_a_irq_lines <= 16'h0000;
    end else begin
      uart_a_io_base <= next_a_io_base; // RL1
      uart_a_irq_lines <= next_a_irq_lines; // RL2
    end
  end

  // Second UART address and power settings
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      uart_b_io_base <= UCR_IO_OFFSET;
      uart_b_decode_en <= 1'h0;
      uart_b_power_down <= 1'h1;
      uart_b_auto_pm_en <= 1'h0;
      uart_b_pins_isolate <= 1'h0;
    end else begin
      uart_b_io_base <= next_b_io_base; // RL1
      uart_b_decode_en <= b_on; // RL4
      uart_b_power_down <= !b_on; // RL4
      uart_b_auto_pm_en <= b_en[UCR_APM_BIT]; // RL5
      uart_b_pins_isolate <= b_isolate; // RL6
    end
  end

  // Second UART mode settings
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      uart_b_test_mode <= 1'h0;
      uart_b_ir_select <= 1'h0;
      uart_b_half_duplex <= 1'h0;
      uart_b_ir_mode <= 3'h0;
      uart_b_ir_mode_valid <= 1'h1;
    end else begin
      uart_b_test_mode <= b_mode[UCR_TEST_BIT]; // RL7
      uart_b_ir_select <= b_ir; // RL8
      uart_b_half_duplex <= next_b_half_duplex; // RL9
      uart_b_ir_mode <= b_irmode; // RL10
      uart_b_ir_mode_valid <= next_b_ir_mode_valid; // RL10
    end
  end

  // Pin routing; the flop adds one cycle of latency on every serial path
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      uart_b_rx_data <= 1'h1;
      second_serial_out_pin <= 1'h1;
      second_serial_out_oe <= 1'h0;
      infrared_transmit_pin <= 1'h0;
      infrared_transmit_oe <= 1'h0;
    end else begin
      uart_b_rx_data <= next_b_rx_data; // RL6
      second_serial_out_pin <= uart_b_tx_data;
      second_serial_out_oe <= next_serial_out_oe; // RL8
      infrared_transmit_pin <= uart_b_tx_data;
      infrared_transmit_oe <= next_ir_out_oe; // RL8
    end
  end

  // Checks
  a_rsv_read_ones: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3
    reg_read && reg_addr == UCR_B_EN_ADDR |=> reg_rdata[7:3] == 5'h1F)
    else $error("enable register reserved bits not read as ones");
  a_rsv_write_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL11
    wr_b_mode |=> b_mode[7:6] == 2'h3)
    else $error("mode register reserved bits changed by write");
  a_base_formula: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
    wr_a_base ##1 !wr_a_base |=> uart_a_io_base == {1'b0, $past(reg_wdata, 2), 3'h0} + 12'h100)
    else $error("first UART base address wrong");
  a_irq_route: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    a_irq[3:0] inside {4'h1, 4'h2, 4'h8, 4'hC, 4'hD, 4'h0} |=> uart_a_irq_lines == 16'h0000)
    else $error("reserved interrupt code routed a line");
  a_disable_power: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    wr_b_en && !reg_wdata[0] ##1 !wr_b_en |=> !uart_b_decode_en && uart_b_power_down)
    else $error("disabled UART still decoded");
  a_apm_follow: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL5
    wr_b_en |=> ##1 uart_b_auto_pm_en == $past(reg_wdata[1], 2))
    else $error("auto power management bit not applied");
  a_leak_isolate: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL6
    uart_b_pins_isolate |-> !second_serial_out_oe && !infrared_transmit_oe && uart_b_rx_data)
    else $error("pins active while isolated");
  a_test_mode: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL7
    1'b1 |=> uart_b_test_mode == $past(b_mode[0]))
    else $error("test mode does not follow register");
  a_ir_route: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    uart_b_ir_select |-> !second_serial_out_oe)
    else $error("serial output driven in infrared mode");
  a_duplex_ir: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL9
    uart_b_half_duplex |-> uart_b_ir_select)
    else $error("half duplex without infrared");
  a_irmode_valid: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
    uart_b_ir_mode_valid |-> uart_b_ir_mode <= 3'h2)
    else $error("reserved infrared mode flagged valid");

  // Reserved bits on read and on write
  a_irq_rsv_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3
    reg_read && reg_addr == UCR_A_IRQ_ADDR |=> reg_rdata[7:4] == 4'hF)
    else $error("interrupt register reserved bits not read as ones");
  a_mode_rsv_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL3
    reg_read && reg_addr == UCR_B_MODE_ADDR |=> reg_rdata[7:6] == 2'h3)
    else $error("mode register reserved bits not read as ones");
  a_irq_rsv_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL11
    wr_a_irq |=> a_irq[7:4] == 4'hF)
    else $error("interrupt register reserved bits changed by write");
  a_en_rsv_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL11
    wr_b_en |=> b_en[7:3] == 5'h1F)
    else $error("enable register reserved bits changed by write");

  // Address, interrupt and power settings
  a_base_b_formula: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL1
    wr_b_base ##1 !wr_b_base |=> uart_b_io_base == {1'h0, $past(reg_wdata, 2), 3'h0} + 12'h100)
    else $error("second UART base address wrong");
  a_irq_valid_line: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL2
    a_irq[3:0] inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF}
    |=> $onehot(uart_a_irq_lines) && uart_a_irq_lines[$past(a_irq[3:0])])
    else $error("valid interrupt code did not route its line");
  a_enable_decode: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL4
    wr_b_en && reg_wdata[0] ##1 !wr_b_en |=> uart_b_decode_en && !uart_b_power_down)
    else $error("enabled UART not decoded");
  a_leak_enters: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL6
    !b_en[0] && b_en[2] |=> uart_b_pins_isolate)
    else $error("pins not isolated in power-down with leakage control");
  a_leak_normal: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL6
    !b_en[2] |=> !uart_b_pins_isolate)
    else $error("pins isolated with leakage control off");

  // Pin routing and mode settings
  a_rx_infrared: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    b_ir && !b_isolate |=> uart_b_rx_data == $past(infrared_receive_pin))
    else $error("receive data not taken from infrared pin");
  a_rx_serial: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    !b_ir && !b_isolate |=> uart_b_rx_data == $past(second_serial_in_pin))
    else $error("receive data not taken from serial pin");
  a_one_driver: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    !b_isolate |=> second_serial_out_oe != infrared_transmit_oe)
    else $error("not exactly one transmit pin driven");
  a_tx_copy: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    1'h1 |=> second_serial_out_pin == $past(uart_b_tx_data)
      && infrared_transmit_pin == $past(uart_b_tx_data))
    else $error("transmit data not copied to pins");
  a_duplex_half: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL9
    b_ir && b_mode[2] |=> uart_b_half_duplex)
    else $error("half duplex not given with infrared");
  a_irmode_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL10
    b_irmode > UCR_IRMODE_ASK |=> !uart_b_ir_mode_valid)
    else $error("reserved infrared mode not flagged");
  a_ir_select_follow: assert property (@(posedge clk_sys) disable iff (!reset_n) // RL8
    1'h1 |=> uart_b_ir_select == $past(b_mode[1]))
    else $error("infrared select does not follow register");
  c_ir_enable: cover property (@(posedge clk_sys) disable iff (!reset_n)
    wr_b_mode && reg_wdata[1] ##2 infrared_transmit_oe);
  c_power_down: cover property (@(posedge clk_sys) disable iff (!reset_n)
    uart_b_pins_isolate);
  c_irq_line: cover property (@(posedge clk_sys) disable iff (!reset_n)
    uart_a_irq_lines[15]);
  c_read_back: cover property (@(posedge clk_sys) disable iff (!reset_n)
    reg_read && reg_addr == UCR_B_MODE_ADDR);
  c_half_duplex: cover property (@(posedge clk_sys) disable iff (!reset_n)
    uart_b_half_duplex);

endmodule // ucr_uart_config_registers

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import ucr_pkg::*;
;
  logic clk_sys, reset_n, reg_write, reg_read, second_serial_in_pin, infrared_receive_pin;
  logic uart_b_tx_data, uart_b_decode_en, uart_b_power_down, uart_b_auto_pm_en, iso;
  logic uart_b_pins_isolate, uart_b_test_mode, uart_b_ir_select, uart_b_half_duplex;
  logic uart_b_ir_mode_valid, uart_b_rx_data, second_serial_out_pin, second_serial_out_oe;
  logic infrared_transmit_pin, infrared_transmit_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [11:0] uart_a_io_base, uart_b_io_base;
  logic [15:0] uart_a_irq_lines;
  logic [2:0] uart_b_ir_mode;
  logic [7:0] ad [6] = '{8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h0F};
  logic [7:0] ex [6] = '{8'h00, 8'hF0, 8'hF8, 8'hC4, 8'h00, 8'h00};
  logic [7:0] rs [4] = '{8'h00, 8'hF0, 8'hF8, 8'hC0};
  int fail_count, n_compared;
  ucr_uart_config_registers ucr_uart_config_registers_i (.clk_sys, .reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .uart_a_io_base, .uart_a_irq_lines,
    .uart_b_io_base, .uart_b_decode_en, .uart_b_power_down, .uart_b_auto_pm_en,
    .uart_b_pins_isolate, .uart_b_test_mode, .uart_b_ir_select, .uart_b_half_duplex,
    .uart_b_ir_mode, .uart_b_ir_mode_valid, .second_serial_in_pin, .infrared_receive_pin,
    .uart_b_tx_data, .uart_b_rx_data, .second_serial_out_pin, .second_serial_out_oe,
    .infrared_transmit_pin, .infrared_transmit_oe);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Strobes are set by every access, so back-to-back calls never leave both strobes high at once
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a;
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  // Derived outputs lag the write by one edge, so checks wait two
  task automatic idle(input int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk_reset;
    idle(1);
    chk("a_base", 16'h0100, uart_a_io_base);
    chk("b_base", 16'h0100, uart_b_io_base);
    chk("pd", 16'h0001, uart_b_power_down);
    for (int i = 0; i < 6; i++) begin
      rd(ad[i]);
      chk("reset", ex[i], d);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial begin
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    second_serial_in_pin = 1'b1;
    infrared_receive_pin = 1'b1;
    uart_b_tx_data = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk_reset;
    idle(1);
    chk("rdata", 16'h0000, reg_rdata);
    for (int i = 1; i < 4; i++) begin
      wr(ad[i], 8'h00);
      rd(ad[i]);
      chk("rsv0", rs[i], d);
      wr(ad[i], 8'hFF);
      rd(ad[i]);
      chk("rsv1", 8'hFF, d);
    end
    wr(8'h0F, 8'hFF);
    rd(8'h0F);
    chk("unmap", 8'h00, d);
    wr(UCR_A_BASE_ADDR, 8'hFF);
    wr(UCR_B_BASE_ADDR, 8'h01);
    idle(2);
    chk("a_base", 16'h08F8, uart_a_io_base);
    chk("b_base", 16'h0108, uart_b_io_base);
    for (int c = 0; c < 16; c++) begin
      wr(UCR_A_IRQ_ADDR, c[7:0]);
      idle(2);
      chk("irq", (16'h0001 << c) & 16'hCEF8, uart_a_irq_lines);
    end
    wr(UCR_B_MODE_ADDR, 8'h00);
    for (int e = 0; e < 8; e++) begin
      wr(UCR_B_EN_ADDR, e[7:0]);
      second_serial_in_pin <= e[1];
      idle(2);
      iso = e[2] & !e[0];
      chk("dec", e[0], uart_b_decode_en);
      chk("pd", !e[0], uart_b_power_down);
      chk("apm", e[1], uart_b_auto_pm_en);
      chk("iso", iso, uart_b_pins_isolate);
      chk("rx", iso | e[1], uart_b_rx_data);
      chk("soe", !iso, second_serial_out_oe);
    end
    wr(UCR_B_EN_ADDR, 8'h01);
    for (int m = 0; m < 64; m++) begin
      wr(UCR_B_MODE_ADDR, m[7:0]);
      infrared_receive_pin <= m[0];
      second_serial_in_pin <= !m[0];
      uart_b_tx_data <= m[2];
      idle(2);
      chk("test", m[0], uart_b_test_mode);
      chk("ir", m[1], uart_b_ir_select);
      chk("rx", !(m[0] ^ m[1]), uart_b_rx_data);
      chk("oe", {m[1], !m[1]}, {infrared_transmit_oe, second_serial_out_oe});
      chk("tx", m[2], m[1] ? infrared_transmit_pin : second_serial_out_pin);
      chk("hd", m[1] & m[2], uart_b_half_duplex);
      chk("irm", {m[5:3], m[5:3] < 3}, {uart_b_ir_mode, uart_b_ir_mode_valid});
    end
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    chk_reset;
    print_verdict;
  end
endmodule // tb_top
